// [inc/pxb_pkg.sv]
// Notes on behaviour
// - ports one, two, three, upper: per-bit direction
// - reset makes ports one to three inputs
// - muxed bus port direction is whole byte
// - expansion: muxed port carries address, then data
// - expansion: upper port outputs high address bits
// - latch strobe pulses while low address shown
// - read strobe low; bus released for data
// - write strobe low only with valid data
// - reset holds read and write strobes high
// - size pins sampled, then output two flags
// - third port lines individually become control lines
// - expansion reaches up to sixty-four kilobytes
// - size selects which upper lines carry address
package pxb_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ    = 250;
  localparam int ALE_NS     = 8;   // least latch strobe width
  localparam int STB_NS     = 16;  // least read/write strobe width
  localparam int ALE_CYC    = (ALE_NS * CLK_MHZ + 999) / 1000;
  localparam int STB_CYC    = (STB_NS * CLK_MHZ + 999) / 1000;

  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_OUT_BASE = 8'h00;  // outputs a,b,c,d,f at 00..04
  localparam logic [7:0] OFF_DIR_BASE = 8'h08;  // directions at 08..0c
  localparam logic [7:0] OFF_CTL_SEL  = 8'h0D;
  localparam logic [7:0] OFF_PIN_BASE = 8'h10;  // pin levels at 10..14
  localparam logic [7:0] OFF_SIZE     = 8'h18;
  localparam logic [7:0] OFF_STRAP    = 8'h19;
  localparam logic [7:0] OFF_ADDR_LO  = 8'h1A;
  localparam logic [7:0] OFF_ADDR_HI  = 8'h1B;
  localparam logic [7:0] OFF_WDATA    = 8'h1C;
  localparam logic [7:0] OFF_RDATA    = 8'h1D;
  localparam logic [7:0] OFF_CMD      = 8'h1E;
  localparam logic [7:0] OFF_STATUS   = 8'h1F;
  localparam int         NPORT        = 5;
  localparam int         PORT_D       = 3;
  localparam int         PORT_F       = 4;
  localparam int         PORT_C       = 2;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int CMD_START = 0;
  localparam int CMD_WRITE = 1;
  localparam int CMD_IO    = 2;
  localparam int CMD_FETCH = 3;
  localparam int STS_BUSY  = 0;
  localparam int STS_DONE  = 1;

  typedef enum logic [2:0] {
    SZ_NONE = 3'h0,
    SZ_256  = 3'h1,
    SZ_4K   = 3'h2,
    SZ_16K  = 3'h3,
    SZ_60K  = 3'h4
  } pxb_size_e;

  // gray along idle, latch, hold, strobe, recover
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_ALE   = 3'b001,
    ST_HOLD  = 3'b011,
    ST_STRB  = 3'b010,
    ST_RECOV = 3'b110
  } pxb_bus_e;

  // upper lines that carry address at each size
  function automatic logic [7:0] pxb_hi_mask(input pxb_size_e sz);
    case (sz)
      SZ_4K:   pxb_hi_mask = 8'h0F;
      SZ_16K:  pxb_hi_mask = 8'h3F;
      SZ_60K:  pxb_hi_mask = 8'hFF;
      default: pxb_hi_mask = 8'h00;
    endcase
  endfunction

  // size pins {1,0} caught after reset release
  function automatic pxb_size_e pxb_strap_size(input logic [1:0] p);
    case (p)
      2'b01:   pxb_strap_size = SZ_4K;
      2'b10:   pxb_strap_size = SZ_16K;
      2'b11:   pxb_strap_size = SZ_60K;
      default: pxb_strap_size = SZ_NONE;
    endcase
  endfunction

endpackage

// [inc/pxb_port_if.sv]
`timescale 1ns/1ps
`default_nettype none
// one port's pad control between core and pad mux
interface pxb_port_if #(parameter int W = 8);
  logic [W-1:0] out;
  logic [W-1:0] dir;
  logic [W-1:0] alt_en;
  logic [W-1:0] alt_o;
  logic [W-1:0] alt_oe;
  logic [W-1:0] pad_o;
  logic [W-1:0] pad_oe;
  modport mux  (input out, dir, alt_en, alt_o, alt_oe, output pad_o, pad_oe);
  modport core (output out, dir, alt_en, alt_o, alt_oe, input pad_o, pad_oe);
endinterface
`default_nettype wire

// [hdl/pxb_sync.sv]
`timescale 1ns/1ps
`default_nettype none
module pxb_sync #(
  parameter int W = 8
) (
  input  wire logic         clk,   // core clock
  input  wire logic         rst_n, // sync reset
  input  wire logic [W-1:0] d,     // asynchronous pin levels
  output logic      [W-1:0] q      // synchronised levels
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } pxb_sync_s;

  pxb_sync_s s_r;
  pxb_sync_s s_nxt;

  // first stage feeds only the second
  always_comb begin
    s_nxt.s1 = d;
    s_nxt.s2 = s_r.s1;
  end

  // no reset on purpose: the stages keep flushing while rst_n is low,
  // so the size pins are already settled at the first edge after release
  always_ff @(posedge clk) begin
    s_r <= s_nxt;
  end

  assign q = s_r.s2;
endmodule
`default_nettype wire

// [hdl/pxb_pin_mux.sv]
`timescale 1ns/1ps
`default_nettype none
module pxb_pin_mux (
  pxb_port_if.mux p  // one port's pad control
);
  // per line: alternate owner wins over port latch and direction
  always_comb begin
    p.pad_o  = (p.alt_en & p.alt_o)  | (~p.alt_en & p.out);
    p.pad_oe = (p.alt_en & p.alt_oe) | (~p.alt_en & p.dir);
  end
endmodule
`default_nettype wire

// [hdl/pxb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module pxb_top
  import pxb_pkg::*;
(
  input  wire logic       clk,                    // 250 MHz core clock
  input  wire logic       rst_n,                  // sync reset, low
  input  wire logic [7:0] reg_addr,               // register index
  input  wire logic [7:0] reg_wdata,              // write data
  input  wire logic       reg_we,                 // write strobe
  input  wire logic       reg_re,                 // read strobe
  output logic      [7:0] reg_rdata,              // read data, next cycle
  input  wire logic [7:0] first_port_lines_i,     // pin levels
  output logic      [7:0] first_port_lines_o,     // pin drive
  output logic      [7:0] first_port_lines_oe,    // pin enable
  input  wire logic [7:0] second_port_lines_i,    // pin levels
  output logic      [7:0] second_port_lines_o,    // pin drive
  output logic      [7:0] second_port_lines_oe,   // pin enable
  input  wire logic [7:0] control_capable_port_lines_i,  // pin levels
  output logic      [7:0] control_capable_port_lines_o,  // pin drive
  output logic      [7:0] control_capable_port_lines_oe, // pin enable
  input  wire logic [7:0] muxed_bus_port_lines_i,  // pin levels
  output logic      [7:0] muxed_bus_port_lines_o,  // pin drive
  output logic      [7:0] muxed_bus_port_lines_oe, // pin enable
  input  wire logic [7:0] upper_address_port_lines_i,  // pin levels
  output logic      [7:0] upper_address_port_lines_o,  // pin drive
  output logic      [7:0] upper_address_port_lines_oe, // pin enable
  input  wire logic [7:0] ctl_alt_out,            // control function drive
  input  wire logic [7:0] ctl_alt_oe,             // control function enable
  output logic            addr_latch_strobe,      // address latch strobe
  output logic            read_strobe_n_o,        // read strobe, low
  output logic            read_strobe_n_oe,       // read strobe enable
  output logic            write_strobe_n_o,       // write strobe, low
  output logic            write_strobe_n_oe,      // write strobe enable
  input  wire logic       memory_size_select_0_i, // size pin 0 level
  output logic            memory_size_select_0_o, // io flag out
  output logic            memory_size_select_0_oe,// size pin 0 enable
  input  wire logic       memory_size_select_1_i, // size pin 1 level
  output logic            memory_size_select_1_o, // opcode_fetch_flag out
  output logic            memory_size_select_1_oe // size pin 1 enable
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [NPORT-1:0][7:0] pout;
    logic [NPORT-1:0][7:0] pdir;
    logic [7:0]            ctl_sel;
    pxb_size_e             size;
    logic                  strap_done;
    logic [1:0]            strap;
    logic [15:0]           eaddr;
    logic [7:0]            ewdata;
    logic [7:0]            erdata;
    logic                  ewrite;
    logic                  eio;
    logic                  efetch;
    logic                  busy;
    logic                  done;
    pxb_bus_e              bst;
    logic [2:0]            cnt;
    logic                  ale_e;
    logic                  rd_e;
    logic                  wr_e;
    logic [7:0]            d_o;
    logic                  d_oe;
    logic                  ale;
    logic                  rd_n;
    logic                  wr_n;
    logic                  strb_oe;
    logic [1:0]            mode_o;
    logic                  mode_oe;
    logic [NPORT-1:0][7:0] pad_o;
    logic [NPORT-1:0][7:0] pad_oe;
    logic [7:0]            rdata;
  } pxb_state_s;

  pxb_state_s            s_r;
  pxb_state_s            s_nxt;
  logic [41:0]           pins_s;
  logic [NPORT-1:0][7:0] pin_lv;
  logic [1:0]            mode_lv;
  logic [NPORT-1:0][7:0] alt_en;
  logic [NPORT-1:0][7:0] alt_o;
  logic [NPORT-1:0][7:0] alt_oe;
  logic [NPORT-1:0][7:0] pad_o_w;
  logic [NPORT-1:0][7:0] pad_oe_w;
  logic                  exp_on;
  logic [7:0]            hmask;

  // ----------------------------------------------------------------
  // pin inputs and pad muxes
  // ----------------------------------------------------------------
  // all pins come from outside, two flops before any use
  pxb_sync #(.W(42)) u_sync (
    .clk   (clk),
    .rst_n (rst_n),
    .d     ({memory_size_select_1_i, memory_size_select_0_i,
             upper_address_port_lines_i, muxed_bus_port_lines_i,
             control_capable_port_lines_i, second_port_lines_i,
             first_port_lines_i}),
    .q     (pins_s)
  );
  assign pin_lv  = pins_s[39:0];
  assign mode_lv = pins_s[41:40];
  assign exp_on  = (s_r.size != SZ_NONE);
  assign hmask   = pxb_hi_mask(s_r.size);

  // alternate owners: control functions, expansion bus
  always_comb begin
    alt_en = '0;
    alt_o  = '0;
    alt_oe = '0;
    alt_en[PORT_C] = s_r.ctl_sel;
    alt_o[PORT_C]  = ctl_alt_out;
    alt_oe[PORT_C] = ctl_alt_oe;
    alt_en[PORT_D] = exp_on ? 8'hFF : 8'h00;
    alt_o[PORT_D]  = s_r.d_o;
    alt_oe[PORT_D] = {8{s_r.d_oe}};
    alt_en[PORT_F] = exp_on ? hmask : 8'h00;
    alt_o[PORT_F]  = s_r.eaddr[15:8];
    alt_oe[PORT_F] = 8'hFF;
  end

  genvar gi;
  generate
    for (gi = 0; gi < NPORT; gi++) begin : g_port
      pxb_port_if #(.W(8)) pif ();
      assign pif.out    = s_r.pout[gi];
      assign pif.dir    = s_r.pdir[gi];
      assign pif.alt_en = alt_en[gi];
      assign pif.alt_o  = alt_o[gi];
      assign pif.alt_oe = alt_oe[gi];
      assign pad_o_w[gi]  = pif.pad_o;
      assign pad_oe_w[gi] = pif.pad_oe;
      pxb_pin_mux u_mux (
        .p (pif.mux)
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // next state: registers, strap, bus sequencer, pads
  // ----------------------------------------------------------------
  always_comb begin
    s_nxt = s_r;
    // register writes; bus address and data frozen while busy
    if (reg_we) begin
      if (reg_addr < OFF_OUT_BASE + 8'(NPORT)) begin
        s_nxt.pout[3'(reg_addr - OFF_OUT_BASE)] = reg_wdata;
      end else if (reg_addr >= OFF_DIR_BASE && reg_addr < OFF_DIR_BASE + 8'(NPORT)) begin
        if (reg_addr == OFF_DIR_BASE + 8'(PORT_D)) begin
          s_nxt.pdir[PORT_D] = {8{reg_wdata[0]}};
        end else begin
          s_nxt.pdir[3'(reg_addr - OFF_DIR_BASE)] = reg_wdata;
        end
      end else begin
        case (reg_addr)
          OFF_CTL_SEL: s_nxt.ctl_sel = reg_wdata;
          OFF_SIZE: begin
            if (!s_r.busy && reg_wdata[2:0] <= SZ_60K) begin
              s_nxt.size = pxb_size_e'(reg_wdata[2:0]);
            end
          end
          OFF_ADDR_LO: if (!s_r.busy) s_nxt.eaddr[7:0]  = reg_wdata;
          OFF_ADDR_HI: if (!s_r.busy) s_nxt.eaddr[15:8] = reg_wdata;
          OFF_WDATA:   if (!s_r.busy) s_nxt.ewdata      = reg_wdata;
          default: ;
        endcase
      end
    end
    // strap caught on the first clock after release
    if (!s_r.strap_done) begin
      s_nxt.strap_done = 1'b1;
      s_nxt.strap      = mode_lv;
      s_nxt.size       = pxb_strap_size(mode_lv);
    end
    // bus sequencer
    case (s_r.bst)
      ST_IDLE: begin
        if (reg_we && reg_addr == OFF_CMD && reg_wdata[CMD_START] && exp_on
            && s_r.strap_done) begin
          s_nxt.ewrite = reg_wdata[CMD_WRITE];
          s_nxt.eio    = reg_wdata[CMD_IO];
          s_nxt.efetch = reg_wdata[CMD_FETCH];
          s_nxt.busy   = 1'b1;
          s_nxt.bst    = ST_ALE;
          s_nxt.cnt    = 3'(ALE_CYC - 1);
          s_nxt.ale_e  = 1'b1;
          s_nxt.d_o    = s_r.eaddr[7:0];
          s_nxt.d_oe   = 1'b1;
        end
      end
      ST_ALE: begin
        if (s_r.cnt == 3'h0) begin
          s_nxt.ale_e = 1'b0;
          s_nxt.bst   = ST_HOLD;
        end else begin
          s_nxt.cnt = s_r.cnt - 3'h1;
        end
      end
      ST_HOLD: begin
        // address held one cycle past the latch strobe fall
        s_nxt.bst  = ST_STRB;
        s_nxt.cnt  = 3'(STB_CYC - 1);
        s_nxt.d_o  = s_r.ewdata;
        s_nxt.d_oe = s_r.ewrite;
        s_nxt.rd_e = !s_r.ewrite;
        s_nxt.wr_e = s_r.ewrite;
      end
      ST_STRB: begin
        if (s_r.cnt == 3'h0) begin
          s_nxt.rd_e = 1'b0;
          s_nxt.wr_e = 1'b0;
          s_nxt.bst  = ST_RECOV;
        end else begin
          s_nxt.cnt = s_r.cnt - 3'h1;
        end
      end
      ST_RECOV: begin
        // synced pins now show data from inside the strobe
        if (!s_r.ewrite) begin
          s_nxt.erdata = pin_lv[PORT_D];
        end
        s_nxt.d_oe = 1'b0;
        s_nxt.busy = 1'b0;
        s_nxt.bst  = ST_IDLE;
      end
      default: s_nxt.bst = ST_IDLE;
    endcase
    // done: the set wins over a clear in the same cycle
    if (reg_we && reg_addr == OFF_STATUS && reg_wdata[STS_DONE]) begin
      s_nxt.done = 1'b0;
    end
    if (s_r.bst == ST_RECOV) begin
      s_nxt.done = 1'b1;
    end
    // pin side, one flop behind the sequencer with the pads
    s_nxt.ale     = s_r.ale_e;
    s_nxt.rd_n    = !s_r.rd_e;
    s_nxt.wr_n    = !s_r.wr_e;
    s_nxt.strb_oe = exp_on;
    s_nxt.mode_o  = {s_r.efetch, s_r.eio};
    s_nxt.mode_oe = s_r.strap_done;
    s_nxt.pad_o   = pad_o_w;
    s_nxt.pad_oe  = pad_oe_w;
    // read data only in the cycle after the read strobe
    s_nxt.rdata = 8'h00;
    if (reg_re) begin
      if (reg_addr < OFF_OUT_BASE + 8'(NPORT)) begin
        s_nxt.rdata = s_r.pout[3'(reg_addr - OFF_OUT_BASE)];
      end else if (reg_addr >= OFF_DIR_BASE && reg_addr < OFF_DIR_BASE + 8'(NPORT)) begin
        s_nxt.rdata = s_r.pdir[3'(reg_addr - OFF_DIR_BASE)];
      end else if (reg_addr >= OFF_PIN_BASE && reg_addr < OFF_PIN_BASE + 8'(NPORT)) begin
        s_nxt.rdata = pin_lv[3'(reg_addr - OFF_PIN_BASE)];
      end else begin
        case (reg_addr)
          OFF_CTL_SEL: s_nxt.rdata = s_r.ctl_sel;
          OFF_SIZE:    s_nxt.rdata = {5'h00, s_r.size};
          OFF_STRAP:   s_nxt.rdata = {6'h00, s_r.strap};
          OFF_ADDR_LO: s_nxt.rdata = s_r.eaddr[7:0];
          OFF_ADDR_HI: s_nxt.rdata = s_r.eaddr[15:8];
          OFF_WDATA:   s_nxt.rdata = s_r.ewdata;
          OFF_RDATA:   s_nxt.rdata = s_r.erdata;
          OFF_CMD:     s_nxt.rdata = {4'h0, s_r.efetch, s_r.eio, s_r.ewrite, 1'b0};
          OFF_STATUS:  s_nxt.rdata = {6'h00, s_r.done, s_r.busy};
          default:     s_nxt.rdata = 8'h00;
        endcase
      end
    end
  end

  // reset: all lines input, strobes driven high
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_r         <= '0;
      s_r.rd_n    <= 1'b1;
      s_r.wr_n    <= 1'b1;
      s_r.strb_oe <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign reg_rdata                     = s_r.rdata;
  assign first_port_lines_o            = s_r.pad_o[0];
  assign first_port_lines_oe           = s_r.pad_oe[0];
  assign second_port_lines_o           = s_r.pad_o[1];
  assign second_port_lines_oe          = s_r.pad_oe[1];
  assign control_capable_port_lines_o  = s_r.pad_o[PORT_C];
  assign control_capable_port_lines_oe = s_r.pad_oe[PORT_C];
  assign muxed_bus_port_lines_o        = s_r.pad_o[PORT_D];
  assign muxed_bus_port_lines_oe       = s_r.pad_oe[PORT_D];
  assign upper_address_port_lines_o    = s_r.pad_o[PORT_F];
  assign upper_address_port_lines_oe   = s_r.pad_oe[PORT_F];
  assign addr_latch_strobe             = s_r.ale;
  assign read_strobe_n_o               = s_r.rd_n;
  assign read_strobe_n_oe              = s_r.strb_oe;
  assign write_strobe_n_o              = s_r.wr_n;
  assign write_strobe_n_oe             = s_r.strb_oe;
  assign memory_size_select_0_o        = s_r.mode_o[0];
  assign memory_size_select_0_oe       = s_r.mode_oe;
  assign memory_size_select_1_o        = s_r.mode_o[1];
  assign memory_size_select_1_oe       = s_r.mode_oe;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  property p_dir_reset;
    $rose(rst_n) |-> (first_port_lines_oe == 8'h00) && (second_port_lines_oe == 8'h00)
      && (control_capable_port_lines_oe == 8'h00);
  endproperty
  a_dir_reset: assert property (p_dir_reset) else $error("port driving after reset");

  property p_dir_bit;
    reg_we && reg_addr == OFF_DIR_BASE && s_r.strap_done |=> ##2
      first_port_lines_oe == $past(reg_wdata, 3);
  endproperty
  a_dir_bit: assert property (p_dir_bit) else $error("first port direction lost");

  property p_d_byte;
    (muxed_bus_port_lines_oe == 8'h00) || (muxed_bus_port_lines_oe == 8'hFF);
  endproperty
  a_d_byte: assert property (p_d_byte) else $error("muxed port split direction");

  property p_ale_addr;
    addr_latch_strobe |-> muxed_bus_port_lines_oe == 8'hFF
      && muxed_bus_port_lines_o == s_r.eaddr[7:0];
  endproperty
  a_ale_addr: assert property (p_ale_addr) else $error("latch strobe without address");

  property p_rd_len;
    $fell(read_strobe_n_o) |-> (!read_strobe_n_o && muxed_bus_port_lines_oe == 8'h00)[*4]
      ##1 read_strobe_n_o;
  endproperty
  a_rd_len: assert property (p_rd_len) else $error("read strobe wrong");

  property p_wr_data;
    !write_strobe_n_o |-> muxed_bus_port_lines_oe == 8'hFF
      && muxed_bus_port_lines_o == s_r.ewdata;
  endproperty
  a_wr_data: assert property (p_wr_data) else $error("write strobe without data");

  property p_strb_reset;
    $rose(rst_n) |-> read_strobe_n_o && write_strobe_n_o && !addr_latch_strobe;
  endproperty
  a_strb_reset: assert property (p_strb_reset) else $error("strobe low at reset");

  property p_hi_addr;
    $stable(s_r.size) && $stable(s_r.eaddr) && exp_on |=>
      ((upper_address_port_lines_oe & $past(hmask)) == $past(hmask))
      && ((upper_address_port_lines_o & $past(hmask)) == ($past(s_r.eaddr[15:8]) & $past(hmask)));
  endproperty
  a_hi_addr: assert property (p_hi_addr) else $error("upper address lines wrong");

  property p_ctl_sel;
    1'b1 |=> (control_capable_port_lines_oe & $past(s_r.ctl_sel))
      == ($past(ctl_alt_oe) & $past(s_r.ctl_sel));
  endproperty
  a_ctl_sel: assert property (p_ctl_sel) else $error("control line not handed over");

  property p_strap;
    $rose(rst_n) |-> !memory_size_select_0_oe ##1 s_r.strap_done ##1 memory_size_select_0_oe;
  endproperty
  a_strap: assert property (p_strap) else $error("size pins not sampled first");

  property p_access_end;
    $rose(s_r.busy) |-> ##[6:10] $fell(s_r.busy);
  endproperty
  a_access_end: assert property (p_access_end) else $error("access did not end");

  c_read:  cover property ($rose(s_r.done) && !s_r.ewrite);
  c_write: cover property ($rose(s_r.done) && s_r.ewrite);
  c_full:  cover property (s_r.size == SZ_60K && addr_latch_strobe);
  c_ctl:   cover property (s_r.ctl_sel != 8'h00);

endmodule
`default_nettype wire

// [sim/pxb_ext_mem.sv]
`timescale 1ns/1ps
`default_nettype none
module pxb_ext_mem (
  input  wire logic       clk,  // core clock
  input  wire logic [7:0] ad,   // muxed bus wire level
  input  wire logic [7:0] hi,   // upper address wire level
  input  wire logic       ale,  // address latch strobe
  input  wire logic       rd_n, // read strobe wire
  input  wire logic       wr_n, // write strobe wire
  output logic      [7:0] d,    // read data drive
  output logic            d_oe  // read data enable
);
  logic [7:0] lat_r;
  logic [7:0] mem [0:65535];
  // ---------------------------------------------------------------
  // latch and memory
  // ---------------------------------------------------------------
  // transparent while strobe high, so a late address still lands
  always_latch if (ale) lat_r = ad;
  // answers only while the read strobe is low
  assign d_oe = !rd_n;
  assign d    = mem[{hi, lat_r}];
  // write data taken while the write strobe is low
  always @(posedge clk) if (!wr_n) mem[{hi, lat_r}] <= ad;
endmodule
`default_nettype wire

// [sim/tb_port_and_expansion_bus.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_port_and_expansion_bus;
  import pxb_pkg::*;
  logic       clk, rst_n, we, re, ale, rd_o, rd_oe, wr_o, wr_oe, m0_o, m0_oe, m1_o, m1_oe;
  logic       md_oe;
  logic [7:0] addr, wdata, rdata, alt_o, alt_oe, md, junk, v;
  logic [7:0] o [5];
  logic [7:0] oe [5];
  logic [7:0] pin [5];
  logic [7:0] msk [4] = '{8'h00, 8'h0F, 8'h3F, 8'hFF};
  int         fails, compares;
  // ---------------------------------------------------------------
  // pins: released lines show a changing pattern, strobes pulled up
  // ---------------------------------------------------------------
  for (genvar k = 0; k < 5; k++) begin : g_pin
    assign pin[k] = (oe[k] & o[k]) | (~oe[k] & ((k == 3 && md_oe) ? md : junk));
  end
  always @(posedge clk) junk <= ~junk;
  initial begin
    clk = 0;
    forever #2 clk = ~clk;
  end
  pxb_top i_pxb_top (.clk(clk), .rst_n(rst_n), .reg_addr(addr), .reg_wdata(wdata),
    .reg_we(we), .reg_re(re), .reg_rdata(rdata), .first_port_lines_i(pin[0]),
    .first_port_lines_o(o[0]), .first_port_lines_oe(oe[0]), .second_port_lines_i(pin[1]),
    .second_port_lines_o(o[1]), .second_port_lines_oe(oe[1]),
    .control_capable_port_lines_i(pin[2]), .control_capable_port_lines_o(o[2]),
    .control_capable_port_lines_oe(oe[2]), .muxed_bus_port_lines_i(pin[3]),
    .muxed_bus_port_lines_o(o[3]), .muxed_bus_port_lines_oe(oe[3]),
    .upper_address_port_lines_i(pin[4]), .upper_address_port_lines_o(o[4]),
    .upper_address_port_lines_oe(oe[4]), .ctl_alt_out(alt_o), .ctl_alt_oe(alt_oe),
    .addr_latch_strobe(ale), .read_strobe_n_o(rd_o), .read_strobe_n_oe(rd_oe),
    .write_strobe_n_o(wr_o), .write_strobe_n_oe(wr_oe),
    .memory_size_select_0_i(m0_oe ? m0_o : 1'b1), .memory_size_select_0_o(m0_o),
    .memory_size_select_0_oe(m0_oe), .memory_size_select_1_i(m1_oe ? m1_o : 1'b1),
    .memory_size_select_1_o(m1_o), .memory_size_select_1_oe(m1_oe));
  pxb_ext_mem i_pxb_ext_mem (.clk(clk), .ad(pin[3]), .hi(pin[4]), .ale(ale),
    .rd_n(rd_oe ? rd_o : 1'b1), .wr_n(wr_oe ? wr_o : 1'b1), .d(md), .d_oe(md_oe));
  // ---------------------------------------------------------------
  // bus tasks and checks
  // ---------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    we    <= 1'b1;
    @(posedge clk);
    we <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    re   <= 1'b1;
    @(posedge clk);
    re <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic chk(input string n, input logic [7:0] g, input logic [7:0] e);
    compares++;
    if (g !== e) begin
      fails++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  // poll status; a hung access leaves busy set
  task automatic wait_idle();
    for (int i = 0; i < 20; i++) begin
      rd(OFF_STATUS, v);
      if (v[STS_BUSY] === 1'b0) break;
    end
    chk("busy", {7'h00, v[STS_BUSY]}, 8'h00);
  endtask
  task automatic t_dirs();
    wr(OFF_SIZE, 8'h00);
    wr(OFF_DIR_BASE, 8'hA5);
    wr(OFF_OUT_BASE, 8'h3C);
    wr(OFF_DIR_BASE + 8'h03, 8'h01);
    wr(OFF_DIR_BASE + 8'h04, 8'h81);
    repeat (2) @(posedge clk);
    #1 chk("a_oe", oe[0], 8'hA5);
    chk("a_drv", o[0] & oe[0], 8'h24);
    chk("f_oe", oe[4], 8'h81);
    chk("d_oe", oe[3], 8'hFF);
    rd(OFF_DIR_BASE + 8'h03, v);
    chk("d_dir", v, 8'hFF);
    rd(OFF_PIN_BASE, v);
    chk("a_pin", v & 8'hA5, 8'h24);
    wr(OFF_DIR_BASE + 8'h04, 8'h00);
  endtask
  task automatic t_ctl();
    wr(OFF_CTL_SEL, 8'h10);
    alt_o  <= 8'h10;
    alt_oe <= 8'h10;
    repeat (3) @(posedge clk);
    #1 chk("c_alt", o[2] & oe[2], 8'h10);
    chk("c_oe", oe[2], 8'h10);
  endtask
  task automatic t_bus(input logic [15:0] a, input logic [7:0] d);
    wr(OFF_ADDR_LO, a[7:0]);
    wr(OFF_ADDR_HI, a[15:8]);
    wr(OFF_WDATA, d);
    wr(OFF_CMD, 8'h03);
    wait_idle();
    chk("ext_mem", i_pxb_ext_mem.mem[a], d);
    chk("flags_wr", {6'h00, m1_o, m0_o}, 8'h00);
    wr(OFF_CMD, 8'h0D);
    wait_idle();
    chk("flags_rd", {6'h00, m1_o, m0_o}, 8'h03);
    rd(OFF_RDATA, v);
    chk("rdata", v, d);
  endtask
  task automatic tally_and_finish();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // ---------------------------------------------------------------
  // main sequence and watchdog
  // ---------------------------------------------------------------
  initial begin
    {rst_n, we, re, addr, wdata, alt_o, alt_oe, fails, compares} = '0;
    junk = 8'h5A;
    repeat (4) @(posedge clk);
    #1 chk("abc_oe", oe[0] | oe[1] | oe[2], 8'h00);
    chk("strobes", {4'h0, rd_o, rd_oe, wr_o, wr_oe}, 8'h0F);
    @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    rd(OFF_STRAP, v);
    chk("strap", v, 8'h03);
    chk("mode_oe", {6'h00, m0_oe, m1_oe}, 8'h03);
    t_dirs();
    t_ctl();
    wr(OFF_ADDR_HI, 8'hC7);
    for (int s = 1; s < 5; s++) begin
      wr(OFF_SIZE, s[7:0]);
      repeat (2) @(posedge clk);
      #1 chk("f_mask", oe[4], msk[s-1]);
      chk("f_hi", o[4] & oe[4], msk[s-1] & 8'hC7);
    end
    t_bus(16'h34_12, 8'hA1);
    t_bus(16'hEF_FF, 8'h5C);
    tally_and_finish();
  end
  initial begin
    #(4 * 6000);
    fails++;
    tally_and_finish();
  end
endmodule
`default_nettype wire
